/* core/position_port_defines.svh */
`ifndef POSITION_PORT_DEFINES_SVH
`define POSITION_PORT_DEFINES_SVH

// register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_POS 12'h004
`define REG_STAT 12'h008
`define REG_IRQ_STAT 12'h00c
`define REG_IRQ_MASK 12'h010
`define REG_BUSIN 12'h014

// control fields
`define CTRL_OE_N 0
`define CTRL_STEER 1
`define CTRL_FREEZE_N 2
`define CTRL_DIR_OUT 3
`define CTRL_RES_LO 4
`define CTRL_RES_HI 5
`define CTRL_RESET_VAL 32'h0000000c

// status fields
`define STAT_BUSY 0
`define STAT_SENSE 1

// interrupt event bits
`define IRQ_WRAP 0
`define IRQ_REVERSE 1
`define IRQ_WIDTH 2

// busy hold count per step; busy stays high one cycle longer than this
`define BUSY_CYCLES 4'h2
`endif

/* core/position_port_pkg.sv */
package position_port_pkg;
    typedef enum logic [1:0] {RES10, RES12, RES14, RES16} resolution_t;
    typedef struct packed {
        logic [15:0] latchReg;
        logic busyReg;
        logic [3:0] busyCnt;
        logic senseReg;
        logic wrapReg;
        logic [15:0] prevPos;
    } tracker_state_t;
endpackage

/* core/wrap_detect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "position_port_defines.svh"
module wrap_detect (
    input wire logic [15:0] prevPos, // previous position
    input wire logic [15:0] newPos, // current position
    input wire logic [15:0] widthMask, // active word bits
    output logic wrap, // major carry seen
    output logic stepUp // positive step
);
    logic prevOnes;
    logic prevZeros;
    logic newOnes;
    logic newZeros;
    // carry between full scale and zero
    always_comb begin
        prevOnes = ((prevPos & widthMask) == widthMask);
        prevZeros = ((prevPos & widthMask) == 16'h0000);
        newOnes = ((newPos & widthMask) == widthMask);
        newZeros = ((newPos & widthMask) == 16'h0000);
        wrap = (prevOnes && newZeros) || (prevZeros && newOnes);
        // a carry from zero to full scale is a down step
        stepUp = prevOnes ? newZeros : (prevZeros && newOnes) ? 1'b0 : (newPos > prevPos);
    end
endmodule
`default_nettype wire

/* core/apb_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "position_port_defines.svh"
module apb_regs (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [15:0] posWord, // latched position
    input wire logic [15:0] busIn, // captured bus input
    input wire logic busy, // busy level
    input wire logic sense, // rotation sense
    input wire logic [`IRQ_WIDTH-1:0] events, // event pulses
    output logic [31:0] ctrl, // control register
    output logic irq // interrupt level
);
    logic [31:0] ctrl_reg;
    logic [`IRQ_WIDTH-1:0] stat_reg;
    logic [`IRQ_WIDTH-1:0] mask_reg;
    logic [31:0] rd_next;
    logic mapped;
    logic wrEn;
    assign wrEn = psel && penable && pwrite;
    assign pready = 1'b1;
    assign ctrl = ctrl_reg;
    assign irq = |(stat_reg & mask_reg);
    // read decode
    always_comb begin
        rd_next = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            `REG_CTRL: rd_next = ctrl_reg;
            `REG_POS: rd_next = {16'h0000, posWord};
            `REG_STAT: rd_next = {30'h0, sense, busy};
            `REG_IRQ_STAT: rd_next = {30'h0, stat_reg};
            `REG_IRQ_MASK: rd_next = {30'h0, mask_reg};
            `REG_BUSIN: rd_next = {16'h0000, busIn};
            default: mapped = 1'b0;
        endcase
    end
    assign prdata = rd_next;
    assign pslverr = psel && penable && !mapped;
    // register writes; event set beats clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET_VAL;
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            if (wrEn && paddr == `REG_CTRL) begin
                ctrl_reg <= pwdata;
            end
            if (wrEn && paddr == `REG_IRQ_MASK) begin
                mask_reg <= pwdata[`IRQ_WIDTH-1:0];
            end
            if (wrEn && paddr == `REG_IRQ_STAT) begin
                stat_reg <= (stat_reg & ~pwdata[`IRQ_WIDTH-1:0]) | events;
            end else begin
                stat_reg <= stat_reg | events;
            end
        end
    end
endmodule
`default_nettype wire

/* core/position_word_bus_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "position_port_defines.svh"
module position_word_bus_port (
    input wire logic clk_sys, // 200 MHz clock
    input wire logic rst_n, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [15:0] trackPos, // converter tracked position
    input wire logic [15:0] positionBusIn, // data lines, input side
    output logic [15:0] positionBusOut, // data lines, output side
    output logic [15:0] positionBusOe, // data lines, drive enables
    output logic busy, // word changing
    output logic rotationSense, // direction level
    output logic wrapPulseOut, // wrap pulse
    output logic irq // interrupt level
);
    position_port_pkg::tracker_state_t st_reg;
    position_port_pkg::tracker_state_t st_next;
    position_port_pkg::resolution_t res;
    logic [31:0] ctrl;
    logic [15:0] widthMask;
    logic [15:0] curPos;
    logic [15:0] busInReg;
    logic wrapSeen;
    logic stepUp;
    logic moved;
    logic outEnable;
    logic [`IRQ_WIDTH-1:0] events;

    assign res = position_port_pkg::resolution_t'(ctrl[`CTRL_RES_HI:`CTRL_RES_LO]);

    // word width from resolution select
    always_comb begin
        case (res)
            position_port_pkg::RES10: widthMask = 16'h03ff;
            position_port_pkg::RES12: widthMask = 16'h0fff;
            position_port_pkg::RES14: widthMask = 16'h3fff;
            position_port_pkg::RES16: widthMask = 16'hffff;
            default: widthMask = 16'hffff;
        endcase
    end

    assign curPos = trackPos & widthMask;
    assign moved = (curPos != st_reg.prevPos);

    wrap_detect u_wrap (
        .prevPos(st_reg.prevPos),
        .newPos(curPos),
        .widthMask(widthMask),
        .wrap(wrapSeen),
        .stepUp(stepUp)
    );

    // tracking, busy, sense, wrap and latch update
    always_comb begin
        st_next = st_reg;
        st_next.wrapReg = 1'b0;
        st_next.prevPos = curPos;
        if (moved) begin
            st_next.busyReg = 1'b1;
            st_next.busyCnt = `BUSY_CYCLES;
            st_next.senseReg = stepUp;
            st_next.wrapReg = wrapSeen;
            if (ctrl[`CTRL_FREEZE_N]) begin
                st_next.latchReg = curPos;
            end
        end else if (st_reg.busyCnt != 4'h0) begin
            st_next.busyCnt = st_reg.busyCnt - 4'h1;
        end else begin
            st_next.busyReg = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= '0;
            busInReg <= 16'h0000;
        end else begin
            st_reg <= st_next;
            busInReg <= positionBusIn;
        end
    end

    // bus drive: direction and enable gate the drivers
    assign outEnable = ctrl[`CTRL_DIR_OUT] && !ctrl[`CTRL_OE_N];
    assign positionBusOe = {16{outEnable}};
    // byte steering onto the low lines
    always_comb begin
        positionBusOut = st_reg.latchReg;
        if (ctrl[`CTRL_STEER]) begin
            positionBusOut = {st_reg.latchReg[15:8], st_reg.latchReg[15:8]};
        end
    end

    assign busy = st_reg.busyReg;
    assign rotationSense = st_reg.senseReg;
    assign wrapPulseOut = st_reg.wrapReg;
    assign events = {moved && (stepUp != st_reg.senseReg), st_reg.wrapReg};

    apb_regs u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .posWord(st_reg.latchReg),
        .busIn(busInReg),
        .busy(st_reg.busyReg),
        .sense(st_reg.senseReg),
        .events(events),
        .ctrl(ctrl),
        .irq(irq)
    );
endmodule
`default_nettype wire

/* test/position_word_bus_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
module position_word_bus_port_props (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic [15:0] trackPos, // position in
    input wire logic [15:0] positionBusOe, // enables
    input wire logic busy, // busy
    input wire logic rotationSense, // sense
    input wire logic wrapPulseOut // wrap
);
    // one domain for every check
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // step, busy, wrap, sense and drive enable checks
    chk_busy_start: assert property ($changed(trackPos[9:0]) |=> busy)
        else $error("no busy after step");
    chk_busy_length: assert property ($rose(busy) |-> busy[*3])
        else $error("busy too short");
    chk_wrap_single: assert property (wrapPulseOut |=> !wrapPulseOut)
        else $error("wrap pulse too long");
    chk_wrap_cause: assert property (
        trackPos == 16'h0 && $past(trackPos) == 16'hffff |=> wrapPulseOut)
        else $error("carry without wrap");
    chk_wrap_down: assert property (
        trackPos == 16'hffff && $past(trackPos) == 16'h0 |=> wrapPulseOut)
        else $error("down carry without wrap");
    chk_wrap_busy: assert property (wrapPulseOut |-> busy)
        else $error("wrap outside step");
    chk_sense_busy: assert property ($changed(rotationSense) |-> busy)
        else $error("sense moved without step");
    chk_sense_up: assert property (trackPos == $past(trackPos) + 16'h1 |=> rotationSense)
        else $error("sense wrong on up step");
    chk_sense_down: assert property (
        trackPos == $past(trackPos) - 16'h1 |=> !rotationSense)
        else $error("sense wrong on down step");
    chk_oe_whole: assert property (positionBusOe inside {16'h0000, 16'hffff})
        else $error("partial drive");
endmodule
bind position_word_bus_port position_word_bus_port_props i_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .trackPos(trackPos), .positionBusOe(positionBusOe), .busy(busy),
    .rotationSense(rotationSense), .wrapPulseOut(wrapPulseOut));
`default_nettype wire

/* test/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk_sys, // clock
    input wire logic [15:0] drvOut, // device value
    input wire logic [15:0] drvOe, // device enables
    input wire logic hostOn, // host drives
    input wire logic [15:0] hostData, // host value
    output logic [15:0] lineLvl // line level
);
    logic [15:0] lastLvl = 16'h0;
    // owner per line; a free line keeps toggling
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            lineLvl[b] = drvOe[b] ? drvOut[b] : hostOn ? hostData[b] : ~lastLvl[b];
        end
    end
    // last level for the toggle
    always_ff @(posedge clk_sys) begin
        lastLvl <= lineLvl;
    end
endmodule
`default_nettype wire

/* test/position_word_bus_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "position_port_defines.svh"
module position_word_bus_port_tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, busy, rotationSense, wrapPulseOut, irq, err, hostOn = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] trackPos = 16'h0, busIn, busOut, busOe, hostData = 16'h0;
    logic [3:0] w;
    int n_fail = 0, n_checks = 0;
    // 200 MHz clock
    initial forever #2.5 clk_sys = ~clk_sys;
    position_word_bus_port i_position_word_bus_port (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trackPos(trackPos),
        .positionBusIn(busIn), .positionBusOut(busOut), .positionBusOe(busOe),
        .busy(busy), .rotationSense(rotationSense), .wrapPulseOut(wrapPulseOut), .irq(irq));
    host_bus_model i_host_bus_model (.clk_sys(clk_sys), .drvOut(busOut), .drvOe(busOe),
        .hostOn(hostOn), .hostData(hostData), .lineLvl(busIn));
    // verdict and end of run
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, then a settle cycle
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
            if (i == 8) begin
                n_fail++;
                summarize();
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // position step, busy window watched, wrap cycles counted
    task step(input logic [15:0] v);
        @(posedge clk_sys);
        trackPos <= v;
        w = 4'h0;
        for (int k = 1; k < 6; k++) begin
            @(posedge clk_sys);
            #1;
            w = w + {3'h0, wrapPulseOut};
            if (k == 1) chk(busy, 1'b1);
            if (k == 4) chk(busy, 1'b0);
        end
    endtask
    task tReset;
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, `CTRL_RESET_VAL);
        chk(busOe, 16'hffff);
        apb(1'b0, 12'hffc, 32'h0);
        chk(err, 1'b1);
    endtask
    task tFreeze;
        step(16'h0001);
        chk(rotationSense, 1'b1);
        chk(busOut, 16'h0001);
        apb(1'b1, `REG_CTRL, 32'h08);
        step(16'h0005);
        chk(busOut, 16'h0001);
        apb(1'b1, `REG_CTRL, 32'h0c);
        chk(busOut, 16'h0001);
        step(16'h0006);
        chk(busOut, 16'h0006);
    endtask
    task tWrap;
        apb(1'b1, `REG_IRQ_MASK, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h08);
        step(16'hffff);
        chk(w, 4'h0);
        apb(1'b1, `REG_IRQ_STAT, 32'h3);
        step(16'h0000);
        chk(w, 4'h1);
        chk(irq, 1'b1);
        step(16'hffff);
        chk(w, 4'h1);
        chk(rotationSense, 1'b0);
        apb(1'b0, `REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `REG_IRQ_STAT, 32'h3);
        chk(irq, 1'b0);
        apb(1'b1, `REG_IRQ_MASK, 32'h0);
        step(16'h0000);
        chk(irq, 1'b0);
        chk(busOut, 16'h0006);
    endtask
    task tSteer;
        apb(1'b1, `REG_CTRL, 32'h0e);
        step(16'h0302);
        chk(busOut, 16'h0303);
        apb(1'b1, `REG_CTRL, 32'h0c);
        chk(busOut, 16'h0302);
    endtask
    task tRes;
        apb(1'b1, `REG_CTRL, 32'h3c);
        step(16'h8000);
        apb(1'b0, `REG_POS, 32'h0);
        chk(rd, 32'h8000);
        apb(1'b0, `REG_STAT, 32'h0);
        chk(rd, 32'h2);
    endtask
    task tBus;
        apb(1'b1, `REG_CTRL, 32'h0d);
        chk(busOe, 16'h0000);
        apb(1'b1, `REG_CTRL, 32'h04);
        chk(busOe, 16'h0000);
        @(posedge clk_sys);
        hostOn <= 1'b1;
        hostData <= 16'ha5c3;
        apb(1'b0, `REG_BUSIN, 32'h0);
        chk(rd, 32'ha5c3);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        tReset();
        tFreeze();
        tWrap();
        tSteer();
        tRes();
        tBus();
        summarize();
    end
endmodule
`default_nettype wire
